// [inc/irq_seq_regs.svh]
// register offsets, field positions, reset values and timing counts of the interrupt sequencer
`ifndef IRQ_SEQ_REGS_SVH
`define IRQ_SEQ_REGS_SVH
`define ADDR_EN_BANK_C 8'h2a
`define ADDR_EN_BANK_E 8'h2c
`define ADDR_EN_BANK_D 8'h2d
`define ADDR_EN_LOW 8'h3a
`define ADDR_EN_HIGH 8'h3b
`define ADDR_LATCH_BANK_C 8'h2b
`define ADDR_LATCH_BANK_E 8'h2e
`define ADDR_LATCH_BANK_D 8'h2f
`define ADDR_LATCH_LOW 8'h3c
`define ADDR_LATCH_HIGH 8'h3d
`define ADDR_NEST_CTRL 8'h3e
`define MASTER_BIT 0
`define EN_RESET 8'h00
`define ACCEPT_CYCLES 12
`define STACK_FRAME 5
`define NEST_WR_CLEAR 2'h1
`define NEST_WR_DOWN 2'h2
`define MAX_LATENCY_OSC 62
`endif

// [inc/irq_seq_pkg.sv]
// types shared by the interrupt sequencer
package irq_seq_pkg;
  typedef enum logic [1:0] {st_run, st_accept} seq_state_t;
  typedef enum logic [2:0] {
    push_none, push_sw_high, push_sw_low, push_pc_ext, push_pc_high, push_pc_low
  } push_sel_t;
endpackage : irq_seq_pkg

// [core/irq_prio_pick.sv]
// fixed priority picker: lowest source number wins
`timescale 1ns/100ps
module irq_prio_pick #(
  parameter int N = 40
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [5:0] idx
);
  // scan from the top so the lowest index overwrites last
  always_comb begin
    found = 1'b0;
    idx = 6'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 6'(i);
      end
    end
  end
endmodule : irq_prio_pick

// [core/irq_enable_accept_sequencer.sv]
// maskable interrupt enable, latch and acceptance sequencer
`timescale 1ns/100ps
`include "irq_seq_regs.svh"
module irq_enable_accept_sequencer #(
  parameter int N_SRC = 40, // source slots, bits 0..2 hold master and non-maskables
  parameter int ACCEPT_CYCLES = `ACCEPT_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr, // special function register address
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic reg_rd, // read strobe, data one cycle later
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [N_SRC-1:0] irq_set, // one-cycle pulses from sources
  input wire logic instr_last, // last cycle of the running instruction
  input wire logic global_on_instr, // sets master enable
  input wire logic global_off_instr, // clears master enable
  input wire logic maskable_return_instr, // pulse when return completes
  input wire logic nonmaskable_return_instr,
  input wire logic nmi_accept, // core accepts a nonmaskable event
  input wire logic [15:0] popped_status_word, // status word from stack on return
  input wire logic [15:0] status_word_in, // live status word of the core
  input wire logic [23:0] prog_counter_in, // return address
  input wire logic [15:0] stack_ptr_in,
  input wire logic [7:0] vector_data, // vector table byte at vector_addr
  output logic accept_busy, // core stalls while high
  output logic [5:0] accept_src,
  output logic push_valid,
  output logic [15:0] push_addr,
  output logic [7:0] push_data,
  output logic [15:0] stack_ptr_out,
  output logic stack_ptr_load,
  output logic [5:0] vector_addr, // slot index, byte offset in vector_byte
  output logic [1:0] vector_byte,
  output logic [23:0] prog_counter_out,
  output logic prog_counter_load, // pulse, handler start
  output logic [3:0] bank_selector,
  output logic master_irq_enable,
  output logic [1:0] nesting_level_flag
);
  // whole state in one packed struct
  typedef struct packed {
    logic master;
    logic [N_SRC-1:0] en;
    logic [N_SRC-1:0] latch;
    logic [3:0] bank;
    logic [3:0] cnt;
    logic [3:0] nest;
    logic [5:0] src;
    logic [23:0] vec;
    logic [2:0] push;
    logic [15:0] sp;
    logic [7:0] rdata;
    logic load;
    logic spload;
    logic pvalid;
    logic [15:0] paddr;
    logic [7:0] pdata;
    irq_seq_pkg::seq_state_t st;
  } state_t;

  state_t cur_reg;
  state_t cur_next;
  logic [N_SRC-1:0] acceptable;
  logic pick_found;
  logic [5:0] pick_idx;
  logic [15:0] sw_snap;

  // enable, latch and master all one
  assign acceptable = cur_reg.latch & cur_reg.en & {N_SRC{cur_reg.master}};

  irq_prio_pick #(.N(N_SRC)) u_pick (
    .req(acceptable),
    .found(pick_found),
    .idx(pick_idx)
  );

  // status word as stacked; acceptance only fires with the master flag set,
  // so the saved flag is one even after the clear has landed mid-push
  assign sw_snap = {status_word_in[15:1], 1'b1};

  // byte lane read of a 40-bit flag vector
  function automatic logic [7:0] lane(input logic [N_SRC-1:0] v, input int b);
    logic [63:0] w;
    w = 64'(v);
    return w[b*8 +: 8];
  endfunction : lane

  // pack the nesting counter into the two-bit flag
  function automatic logic [1:0] nest_flag(input logic [3:0] n);
    return (n > 4'h3) ? 2'h3 : n[1:0];
  endfunction : nest_flag

  // next-state logic
  always_comb begin
    cur_next = cur_reg;
    cur_next.load = 1'b0;
    cur_next.spload = 1'b0;
    cur_next.pvalid = 1'b0;
    cur_next.rdata = 8'h00;
    // sources raise latches; set wins over any clear below except the forced zero of bits 2:0
    // register reads, answer on the next cycle
    if (reg_rd) begin
      if (reg_addr == `ADDR_EN_LOW) begin
        cur_next.rdata = {cur_reg.en[7:1], cur_reg.master};
      end else if (reg_addr == `ADDR_EN_HIGH) begin
        cur_next.rdata = lane(cur_reg.en, 1);
      end else if (reg_addr == `ADDR_EN_BANK_E) begin
        cur_next.rdata = lane(cur_reg.en, 2);
      end else if (reg_addr == `ADDR_EN_BANK_D) begin
        cur_next.rdata = lane(cur_reg.en, 3);
      end else if (reg_addr == `ADDR_EN_BANK_C) begin
        cur_next.rdata = lane(cur_reg.en, 4);
      end else if (reg_addr == `ADDR_LATCH_LOW) begin
        cur_next.rdata = lane(cur_reg.latch, 0);
      end else if (reg_addr == `ADDR_LATCH_HIGH) begin
        cur_next.rdata = lane(cur_reg.latch, 1);
      end else if (reg_addr == `ADDR_LATCH_BANK_E) begin
        cur_next.rdata = lane(cur_reg.latch, 2);
      end else if (reg_addr == `ADDR_LATCH_BANK_D) begin
        cur_next.rdata = lane(cur_reg.latch, 3);
      end else if (reg_addr == `ADDR_LATCH_BANK_C) begin
        cur_next.rdata = lane(cur_reg.latch, 4);
      end else if (reg_addr == `ADDR_NEST_CTRL) begin
        cur_next.rdata = {6'h00, nest_flag(cur_reg.nest)};
      end
    end
    // register writes; latch bits can only be written to zero
    if (reg_wr) begin
      if (reg_addr == `ADDR_EN_LOW) begin
        cur_next.master = reg_wdata[`MASTER_BIT];
        cur_next.en[7:1] = reg_wdata[7:1];
      end else if (reg_addr == `ADDR_EN_HIGH) begin
        cur_next.en[15:8] = reg_wdata;
      end else if (reg_addr == `ADDR_EN_BANK_E) begin
        cur_next.en[23:16] = reg_wdata;
      end else if (reg_addr == `ADDR_EN_BANK_D) begin
        cur_next.en[31:24] = reg_wdata;
      end else if (reg_addr == `ADDR_EN_BANK_C) begin
        cur_next.en[39:32] = reg_wdata;
      end else if (reg_addr == `ADDR_LATCH_LOW) begin
        cur_next.latch[7:0] = cur_reg.latch[7:0] & reg_wdata;
      end else if (reg_addr == `ADDR_LATCH_HIGH) begin
        cur_next.latch[15:8] = cur_reg.latch[15:8] & reg_wdata;
      end else if (reg_addr == `ADDR_LATCH_BANK_E) begin
        cur_next.latch[23:16] = cur_reg.latch[23:16] & reg_wdata;
      end else if (reg_addr == `ADDR_LATCH_BANK_D) begin
        cur_next.latch[31:24] = cur_reg.latch[31:24] & reg_wdata;
      end else if (reg_addr == `ADDR_LATCH_BANK_C) begin
        cur_next.latch[39:32] = cur_reg.latch[39:32] & reg_wdata;
      end else if (reg_addr == `ADDR_NEST_CTRL) begin
        // codes 00 and 11 are reserved and ignored
        if (reg_wdata[1:0] == `NEST_WR_CLEAR) begin
          cur_next.nest = 4'h0;
        end else if (reg_wdata[1:0] == `NEST_WR_DOWN) begin
          // wraps below zero; software owns the count here
          cur_next.nest = cur_reg.nest - 4'h1;
        end
      end
    end
    // master enable instructions
    if (global_on_instr) begin
      cur_next.master = 1'b1;
    end else if (global_off_instr) begin
      cur_next.master = 1'b0;
    end
    // return instructions end the service task
    if (maskable_return_instr) begin
      cur_next.master = 1'b1;
      cur_next.nest = cur_reg.nest - 4'h1;
      cur_next.bank = popped_status_word[11:8];
      cur_next.sp = stack_ptr_in + 16'(`STACK_FRAME);
      cur_next.spload = 1'b1;
    end else if (nonmaskable_return_instr) begin
      // saved master flag only comes back if it was set
      cur_next.master = popped_status_word[`MASTER_BIT];
      cur_next.nest = cur_reg.nest - 4'h1;
      cur_next.bank = popped_status_word[11:8];
      cur_next.sp = stack_ptr_in + 16'(`STACK_FRAME);
      cur_next.spload = 1'b1;
    end
    case (cur_reg.st)
      irq_seq_pkg::st_run: begin
        // sample only at the instruction boundary
        if (instr_last && pick_found && !nmi_accept) begin
          cur_next.st = irq_seq_pkg::st_accept;
          cur_next.master = 1'b0;
          cur_next.latch[pick_idx] = 1'b0;
          cur_next.src = pick_idx;
          cur_next.cnt = 4'h0;
          cur_next.push = 3'(irq_seq_pkg::push_sw_high);
          cur_next.sp = stack_ptr_in;
          cur_next.paddr = stack_ptr_in;
          cur_next.pdata = sw_snap[15:8];
          cur_next.pvalid = 1'b1;
        end
      end
      irq_seq_pkg::st_accept: begin
        // one step per machine cycle, fixed length
        cur_next.cnt = cur_reg.cnt + 4'h1;
        case (cur_reg.cnt)
          4'h0: begin
            cur_next.pvalid = 1'b1;
            cur_next.paddr = cur_reg.sp - 16'h0001;
            cur_next.pdata = sw_snap[7:0];
          end
          4'h1: begin
            cur_next.pvalid = 1'b1;
            cur_next.paddr = cur_reg.sp - 16'h0002;
            cur_next.pdata = prog_counter_in[23:16];
          end
          4'h2: begin
            cur_next.pvalid = 1'b1;
            cur_next.paddr = cur_reg.sp - 16'h0003;
            cur_next.pdata = prog_counter_in[15:8];
          end
          4'h3: begin
            cur_next.pvalid = 1'b1;
            cur_next.paddr = cur_reg.sp - 16'h0004;
            cur_next.pdata = prog_counter_in[7:0];
          end
          4'h4: begin
            cur_next.sp = cur_reg.sp - 16'(`STACK_FRAME);
            cur_next.spload = 1'b1;
          end
          4'h6: cur_next.vec[7:0] = vector_data;
          4'h7: cur_next.vec[15:8] = vector_data;
          4'h8: cur_next.vec[23:16] = vector_data;
          4'h9: cur_next.bank = cur_reg.bank + vector_data[7:4];
          default: begin
          end
        endcase
        if (cur_reg.cnt == 4'(ACCEPT_CYCLES - 2)) begin
          cur_next.nest = cur_reg.nest + 4'h1;
          cur_next.load = 1'b1;
          cur_next.st = irq_seq_pkg::st_run;
        end
      end
      default: cur_next.st = irq_seq_pkg::st_run;
    endcase
    // new requests beat every clear this cycle, except in bits 2:0, which are held at zero
    cur_next.latch = cur_next.latch | irq_set;
    cur_next.latch[2:0] = 3'h0;
  end

  // state register, master and enables clear on reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_reg <= '0;
      cur_reg.en <= {N_SRC{1'b0}};
      cur_reg.st <= irq_seq_pkg::st_run;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // vector table read address: byte 0..2 entry, byte 3 bank code
  // each byte is presented in the cycle whose closing edge captures it,
  // since the table answers combinationally
  always_comb begin
    vector_byte = 2'h0;
    if (cur_reg.cnt == 4'h7) begin
      vector_byte = 2'h1;
    end else if (cur_reg.cnt == 4'h8) begin
      vector_byte = 2'h2;
    end else if (cur_reg.cnt >= 4'h9) begin
      vector_byte = 2'h3;
    end
  end

  assign vector_addr = cur_reg.src;
  assign accept_busy = (cur_reg.st == irq_seq_pkg::st_accept);
  assign accept_src = cur_reg.src;
  assign push_valid = cur_reg.pvalid;
  assign push_addr = cur_reg.paddr;
  assign push_data = cur_reg.pdata;
  assign stack_ptr_out = cur_reg.sp;
  assign stack_ptr_load = cur_reg.spload;
  assign prog_counter_out = cur_reg.vec;
  assign prog_counter_load = cur_reg.load;
  assign bank_selector = cur_reg.bank;
  assign master_irq_enable = cur_reg.master;
  assign nesting_level_flag = nest_flag(cur_reg.nest);
  assign reg_rdata = cur_reg.rdata;
endmodule : irq_enable_accept_sequencer

// [sim/irq_seq_assertions.sv]
// port-level assertions for the interrupt acceptance sequencer
`timescale 1ns/100ps
module irq_seq_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic instr_last,
  input wire logic maskable_return_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic [15:0] popped_status_word,
  input wire logic [15:0] stack_ptr_in,
  input wire logic accept_busy,
  input wire logic push_valid,
  input wire logic stack_ptr_load,
  input wire logic [15:0] stack_ptr_out,
  input wire logic prog_counter_load,
  input wire logic [3:0] bank_selector,
  input wire logic master_irq_enable,
  input wire logic [1:0] nesting_level_flag
);
  // one clock domain, reset quiets everything but the reset check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // five pushes back to back, then the stack pointer update
  property p_push_frame;
    $rose(accept_busy) |-> push_valid[*5] ##1 (stack_ptr_load && !push_valid);
  endproperty
  a_push_frame: assert property (p_push_frame) else $error("push frame wrong");
  property p_sp_down;
    stack_ptr_load && accept_busy |-> stack_ptr_out == stack_ptr_in - 16'h5;
  endproperty
  a_sp_down: assert property (p_sp_down) else $error("stack pointer not down five");
  property p_master_off;
    $rose(accept_busy) |-> !master_irq_enable;
  endproperty
  a_master_off: assert property (p_master_off) else $error("master left on");
  // handler start lands late in the twelve-cycle frame, never early
  property p_handler_start;
    $rose(accept_busy) |-> ##9 !prog_counter_load ##[1:2] prog_counter_load;
  endproperty
  a_handler_start: assert property (p_handler_start) else $error("handler start off");
  property p_was_enabled;
    $rose(accept_busy) |-> $past(master_irq_enable);
  endproperty
  a_was_enabled: assert property (p_was_enabled) else $error("accepted while masked");
  property p_sample_point;
    $rose(accept_busy) |-> $past(instr_last);
  endproperty
  a_sample_point: assert property (p_sample_point) else $error("accepted mid instruction");
  property p_maskable_return_instr_master;
    maskable_return_instr |=> master_irq_enable;
  endproperty
  a_maskable_return_instr_master: assert property (p_maskable_return_instr_master) else $error("return left master off");
  property p_bank_restore;
    maskable_return_instr || nonmaskable_return_instr |=>
      bank_selector == $past(popped_status_word[11:8]);
  endproperty
  a_bank_restore: assert property (p_bank_restore) else $error("bank not restored");
  property p_nest_up;
    $rose(accept_busy) && nesting_level_flag == 2'h0 |-> ##[10:13] nesting_level_flag == 2'h1;
  endproperty
  a_nest_up: assert property (p_nest_up) else $error("nesting not counted");
  // reset itself must be watched, so no disable here
  property p_reset_clear;
    disable iff (1'b0) srst |=> !master_irq_enable && nesting_level_flag == 2'h0 && !accept_busy;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
  cover property ($rose(accept_busy));
  cover property (maskable_return_instr);
  cover property (nonmaskable_return_instr);
endmodule : irq_seq_assertions

// [sim/core_model.sv]
// core-side model: instruction pacing, vector table and core state
`timescale 1ns/100ps
module core_model #(
  parameter int INSTR_LEN = 4 // cycles per modelled instruction, at most 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic accept_busy,
  input wire logic [5:0] vector_addr,
  input wire logic [1:0] vector_byte,
  output logic instr_last,
  output logic [7:0] vector_data,
  output logic [15:0] status_word_in,
  output logic [23:0] prog_counter_in,
  output logic [15:0] stack_ptr_in
);
  logic [3:0] cyc_reg; // position inside the running instruction
  // the core stalls while the sequencer owns it
  always_ff @(posedge core_clk) begin
    if (srst || accept_busy || instr_last) cyc_reg <= 4'h0;
    else cyc_reg <= cyc_reg + 4'h1;
  end
  assign instr_last = cyc_reg == 4'(INSTR_LEN - 1) && !accept_busy && !srst;
  // entry is 00_80_slot; bank code moves handler to bank one
  always_comb begin
    case (vector_byte)
      2'h0: vector_data = {2'h0, vector_addr};
      2'h1: vector_data = 8'h80;
      2'h2: vector_data = 8'h00;
      default: vector_data = 8'h10;
    endcase
  end
  assign status_word_in = 16'h0034; // bank zero, master bit clear
  assign prog_counter_in = 24'h0a0b0c;
  assign stack_ptr_in = 16'h0200;
endmodule : core_model

// [sim/test_irq_enable_accept_sequencer.sv]
// self-checking bench for the interrupt enable and acceptance sequencer
`timescale 1ns/100ps
`include "irq_seq_regs.svh"
module test_irq_enable_accept_sequencer;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic core_clk, srst, reg_wr, reg_rd, instr_last, global_on_instr, global_off_instr;
  logic maskable_return_instr, nonmaskable_return_instr, nmi_accept;
  logic accept_busy, push_valid, stack_ptr_load, prog_counter_load, master_irq_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vector_data, push_data;
  logic [39:0] irq_set;
  logic [15:0] popped_status_word, status_word_in, stack_ptr_in, push_addr, stack_ptr_out;
  logic [23:0] prog_counter_in, prog_counter_out;
  logic [5:0] accept_src, vector_addr;
  logic [1:0] vector_byte, nesting_level_flag;
  logic [3:0] bank_selector;
  logic [7:0] pushed[$]; // bytes seen on the stack port
  logic [15:0] pushed_at[$]; // stack addresses of those bytes
  logic [7:0] exp_push[5] = '{8'h00, 8'h35, 8'h0a, 8'h0b, 8'h0c}; // master was one
  int mismatches, compares, i;
  // only documented enable bits, plus one unmapped place
  row_t rows[6] = '{'{`ADDR_EN_LOW, 8'h68, 8'h68}, '{`ADDR_EN_HIGH, 8'h95, 8'h95},
    '{`ADDR_EN_BANK_E, 8'h55, 8'h55}, '{`ADDR_EN_BANK_D, 8'hed, 8'hed},
    '{`ADDR_EN_BANK_C, 8'hdf, 8'hdf}, '{8'h40, 8'hff, 8'h00}};
  irq_enable_accept_sequencer i_dut (.core_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .irq_set, .instr_last, .global_on_instr, .global_off_instr,
    .maskable_return_instr, .nonmaskable_return_instr, .nmi_accept, .popped_status_word,
    .status_word_in, .prog_counter_in, .stack_ptr_in, .vector_data, .accept_busy,
    .accept_src, .push_valid, .push_addr, .push_data, .stack_ptr_out, .stack_ptr_load,
    .vector_addr, .vector_byte, .prog_counter_out, .prog_counter_load, .bank_selector,
    .master_irq_enable, .nesting_level_flag);
  core_model i_core (.core_clk, .srst, .accept_busy, .vector_addr, .vector_byte,
    .instr_last, .vector_data, .status_word_in, .prog_counter_in, .stack_ptr_in);
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // capture pushes before this edge's updates land
  always @(posedge core_clk) begin
    if (push_valid === 1'b1) begin
      pushed.push_back(push_data);
      pushed_at.push_back(push_addr);
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  // read data only stands the cycle after the strobe
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check("rdata", reg_rdata, exp);
  endtask : rdchk
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse
  // bounded wait on a design output
  task automatic wait_hi(ref logic s, input int lim);
    for (int k = 0; k < lim && s !== 1'b1; k++) @(negedge core_clk);
    check("wait", s, 1'b1);
  endtask : wait_hi
  task results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    {reg_wr, reg_rd, global_on_instr, global_off_instr, nmi_accept} = '0;
    {maskable_return_instr, nonmaskable_return_instr, reg_addr, reg_wdata} = '0;
    irq_set = '0;
    popped_status_word = '0;
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    rdchk(`ADDR_EN_LOW, 8'h00);
    rdchk(`ADDR_EN_BANK_C, 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    // masked: requests wait in their latches
    @(negedge core_clk);
    irq_set = 40'h68;
    @(negedge core_clk);
    irq_set = '0;
    repeat (30) @(negedge core_clk);
    check("busy", accept_busy, 1'b0);
    rdchk(`ADDR_LATCH_LOW, 8'h68);
    wr(`ADDR_EN_LOW, 8'h28);
    pulse(global_on_instr);
    wait_hi(accept_busy, 20);
    check("src", accept_src, 6'h03);
    wait_hi(prog_counter_load, 20);
    check("pc", prog_counter_out, 24'h008003);
    check("bank", bank_selector, 4'h1);
    check("master", master_irq_enable, 1'b0);
    @(negedge core_clk);
    check("nest", nesting_level_flag, 2'h1);
    for (i = 0; i < 5; i++) begin
      check("push", pushed[i], exp_push[i]);
      check("push_at", pushed_at[i], 16'h0200 - i[15:0]);
    end
    rdchk(`ADDR_LATCH_LOW, 8'h60);
    // handler drops its own enable with a plain write before any re-enable
    wr(`ADDR_EN_LOW, 8'h20);
    rdchk(`ADDR_EN_LOW, 8'h20);
    // a nonmaskable event at the sample point holds off the pending source
    nmi_accept = 1'b1;
    popped_status_word = 16'h0001;
    pulse(maskable_return_instr);
    check("master", master_irq_enable, 1'b1);
    check("bank", bank_selector, 4'h0);
    check("nest", nesting_level_flag, 2'h0);
    repeat (8) @(negedge core_clk);
    check("busy", accept_busy, 1'b0);
    nmi_accept = 1'b0;
    wait_hi(accept_busy, 20);
    check("src", accept_src, 6'h05);
    wait_hi(prog_counter_load, 20);
    @(negedge core_clk);
    wr(`ADDR_NEST_CTRL, 8'h02);
    rdchk(`ADDR_NEST_CTRL, 8'h00);
    // count down from zero wraps with no underflow guard
    wr(`ADDR_NEST_CTRL, 8'h02);
    rdchk(`ADDR_NEST_CTRL, 8'h03);
    wr(`ADDR_NEST_CTRL, 8'h01);
    rdchk(`ADDR_NEST_CTRL, 8'h00);
    popped_status_word = 16'h0000;
    pulse(nonmaskable_return_instr);
    check("master", master_irq_enable, 1'b0);
    check("bank", bank_selector, 4'h0);
    pulse(global_on_instr);
    check("master", master_irq_enable, 1'b1);
    pulse(global_off_instr);
    check("master", master_irq_enable, 1'b0);
    // second reset in mid-run, with master set, enables written, count wrapped
    pulse(global_on_instr);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    check("master", master_irq_enable, 1'b0);
    check("nest", nesting_level_flag, 2'h0);
    rdchk(`ADDR_EN_HIGH, 8'h00);
    results();
  end
endmodule : test_irq_enable_accept_sequencer
bind irq_enable_accept_sequencer irq_seq_assertions i_chk (.core_clk, .srst, .instr_last,
  .maskable_return_instr, .nonmaskable_return_instr, .popped_status_word, .stack_ptr_in,
  .accept_busy, .push_valid, .stack_ptr_load, .stack_ptr_out, .prog_counter_load,
  .bank_selector, .master_irq_enable, .nesting_level_flag);
